// [verilog/tear_scan_ctrl.sv]
// tear sync and scan order command decoder, top level
`timescale 1ns/10ps
`include "tear_scan_defs.svh"
`default_nettype none

module tear_scan_ctrl
  import tear_scan_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // host command pins
  input wire logic cs_n_i,
  input wire logic cmd_data_select_i,
  input wire logic write_strobe_n_i,
  input wire logic read_strobe_n_i,
  input wire logic [7:0] data_i,
  // driver state and blanking timing, same clock
  input wire logic sleep_mode_i,
  input wire logic vblank_i,
  input wire logic hblank_i,
  // tear sync pin and state
  output logic tear_sync_out_o,
  output logic tear_enabled_o,
  output logic tear_line_mode_sel_o,
  // scan order setting
  output logic [7:0] scan_order_o,
  output logic row_order_bit_o,
  output logic column_order_bit_o,
  output logic row_column_exchange_bit_o,
  output logic refresh_direction_bit_o,
  output logic colour_order_bit_o,
  output logic horizontal_mirror_bit_o,
  output logic vertical_mirror_bit_o
);

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops; assertion stays asynchronous
  logic rst_n_meta;
  logic rst_n;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_n_meta <= 1'h0;
      rst_n <= 1'h0;
    end
    else
    begin
      rst_n_meta <= 1'h1;
      rst_n <= rst_n_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // host write port
  // one byte per rising strobe edge, about three clocks behind the pin
  cmd_bus_if bus_link();

  host_write_port u_port
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .cs_n_i(cs_n_i),
    .cmd_data_select_i(cmd_data_select_i),
    .write_strobe_n_i(write_strobe_n_i),
    .read_strobe_n_i(read_strobe_n_i),
    .data_i(data_i),
    .bus(bus_link.src)
  );

  logic cmd_take;
  logic par_take;
  cmd_byte_t rx_byte;

  assign cmd_take = bus_link.byte_valid && !bus_link.is_data;
  assign par_take = bus_link.byte_valid && bus_link.is_data;
  assign rx_byte = bus_link.byte_val;

  ////////////////////////////////////////////////////////////////////////
  // command decoder
  cmd_state_e state;
  cmd_state_e next_state;
  logic tear_en;
  logic line_mode;
  logic [7:0] scan_reg;

  // a new command byte always restarts decoding, even mid-parameter
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE,
      ST_TEAR_PARAM,
      ST_TEAR_SKIP,
      ST_SCAN_PARAM:
      begin
        if (cmd_take)
        begin
          if (rx_byte == `CMD_TEAR_ON)
            next_state = tear_en ? ST_TEAR_SKIP : ST_TEAR_PARAM;
          else if (rx_byte == `CMD_SCAN_ORDER)
            next_state = ST_SCAN_PARAM;
          else
            next_state = ST_IDLE;
        end
        else if (par_take)
          next_state = ST_IDLE; // extra parameters fall away here
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////
  // tear enable and line mode; only these two commands touch them
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tear_en <= `TEAR_EN_RESET;
      line_mode <= `LINE_MODE_RESET;
    end
    else if (cmd_take && rx_byte == `CMD_TEAR_OFF)
      tear_en <= 1'h0;
    else if (par_take && state == ST_TEAR_PARAM)
    begin
      tear_en <= 1'h1;
      line_mode <= rx_byte[`LINE_MODE_BIT];
    end
  end

  // scan order byte; unsupported latch bit is stored as zero
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      scan_reg <= `SCAN_ORDER_RESET;
    else if (par_take && state == ST_SCAN_PARAM)
      scan_reg <= rx_byte & `SCAN_ORDER_WRITE_MASK;
  end

  ////////////////////////////////////////////////////////////////////////
  // tear sync pin; registered so blanking glitches do not reach the pin.
  // the refresh direction bit is deliberately not an input here
  logic next_tear;

  always_comb
  begin
    next_tear = 1'h0;
    if (sleep_mode_i || !tear_en)
      next_tear = 1'h0;
    else if (line_mode == `LINE_MODE_VBLANK)
      next_tear = vblank_i;
    else
      next_tear = vblank_i || hblank_i;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      tear_sync_out_o <= 1'h0;
    else
      tear_sync_out_o <= next_tear;
  end

  ////////////////////////////////////////////////////////////////////////
  // setting outputs, straight from the held registers
  assign tear_enabled_o = tear_en;
  assign tear_line_mode_sel_o = line_mode;
  assign scan_order_o = scan_reg;
  assign row_order_bit_o = scan_reg[`ROW_ORDER_POS];
  assign column_order_bit_o = scan_reg[`COLUMN_ORDER_POS];
  assign row_column_exchange_bit_o =
    scan_reg[`ROW_COLUMN_EXCHANGE_POS];
  assign refresh_direction_bit_o = scan_reg[`REFRESH_DIRECTION_POS];
  assign colour_order_bit_o = scan_reg[`COLOUR_ORDER_POS];
  assign horizontal_mirror_bit_o = scan_reg[`HORIZONTAL_MIRROR_POS];
  assign vertical_mirror_bit_o = scan_reg[`VERTICAL_MIRROR_POS];

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  // command decode and tear enable
  chk_tear_enable_set: assert property (
    (par_take && state == ST_TEAR_PARAM) |=>
      tear_en && line_mode == $past(rx_byte[0]))
    else $error("tear enable parameter not applied");

  // tear pin content, one edge behind its inputs
  chk_vblank_only: assert property (
    (tear_en && !line_mode && !sleep_mode_i && !cmd_take && !par_take)
      |=> tear_sync_out_o == $past(vblank_i))
    else $error("tear output not vblank in line mode 0");

  chk_both_blank: assert property (
    (tear_en && line_mode && !sleep_mode_i && !cmd_take && !par_take)
      |=> tear_sync_out_o == $past(vblank_i || hblank_i))
    else $error("tear output not v or h blank in line mode 1");

  chk_sleep_low: assert property (
    sleep_mode_i [*2] |-> ##1 !tear_sync_out_o)
    else $error("tear output not low in sleep");

  chk_refresh_ignored: assert property (
    ($changed(scan_reg[`REFRESH_DIRECTION_POS]) && $past(tear_en) &&
     !$past(sleep_mode_i)) |->
      tear_sync_out_o == $past(line_mode ? (vblank_i || hblank_i)
                                         : vblank_i))
    else $error("tear output disturbed by refresh direction");

  chk_enable_ignored: assert property (
    (tear_en && cmd_take && rx_byte == 8'h35) |=>
      state == ST_TEAR_SKIP ##1 (tear_en && $stable(line_mode)))
    else $error("repeated tear enable not ignored");

  chk_skip_param: assert property (
    (par_take && state == ST_TEAR_SKIP) |=>
      tear_en && $stable(line_mode))
    else $error("parameter of repeated tear enable applied");

  chk_restart_decode: assert property (
    (cmd_take && rx_byte == `CMD_SCAN_ORDER) |=> state == ST_SCAN_PARAM)
    else $error("scan order command not decoded");

  // scan order storage and isolation
  chk_scan_store: assert property (
    (par_take && state == ST_SCAN_PARAM) |=>
      scan_reg == ($past(rx_byte) & 8'hfb) && state == ST_IDLE)
    else $error("scan order byte not stored");

  chk_scan_isolated: assert property (
    (par_take && state == ST_SCAN_PARAM) |=>
      $stable(tear_en) && $stable(line_mode))
    else $error("scan order write disturbed tear state");

  chk_tear_disable: assert property (
    (cmd_take && rx_byte == 8'h34) |=> !tear_en ##1 !tear_sync_out_o)
    else $error("tear disable not applied");

  chk_off_low: assert property (
    !tear_en |=> !tear_sync_out_o)
    else $error("tear output high while disabled");

  chk_settings_hold: assert property (
    !bus_link.byte_valid |=>
      $stable(scan_reg) && $stable(tear_en) && $stable(line_mode))
    else $error("settings changed without a write");

  chk_stray_param: assert property (
    (par_take && state == ST_IDLE) |=>
      $stable(scan_reg) && $stable(tear_en) && $stable(line_mode))
    else $error("stray parameter changed a setting");

  chk_other_cmd: assert property (
    (cmd_take && rx_byte != `CMD_TEAR_OFF && rx_byte != `CMD_TEAR_ON &&
     rx_byte != `CMD_SCAN_ORDER) |=>
      state == ST_IDLE && $stable(scan_reg) && $stable(tear_en))
    else $error("unknown command changed decoder state");

  ////////////////////////////////////////////////////////////////////////
  // main scenarios worth seeing
  cov_tear_line_mode0: cover property (
    par_take && state == ST_TEAR_PARAM && !rx_byte[0] ##1 tear_en);
  cov_tear_line_mode1: cover property (
    par_take && state == ST_TEAR_PARAM && rx_byte[0] ##1 tear_en);
  cov_scan_write: cover property (par_take && state == ST_SCAN_PARAM);
  cov_tear_skip: cover property (state == ST_TEAR_SKIP ##1 par_take);
  cov_tear_off: cover property (tear_en ##1 !tear_en);

endmodule

`default_nettype wire

// [verilog/tear_scan_defs.svh]
// command codes, field positions and reset values for the tear/scan block
`ifndef TEAR_SCAN_DEFS_SVH
`define TEAR_SCAN_DEFS_SVH

// command bytes, sent with the command/data select low
`define CMD_TEAR_OFF 8'h34
`define CMD_TEAR_ON 8'h35
`define CMD_SCAN_ORDER 8'h36

// tear sync parameter layout
`define LINE_MODE_BIT 0
`define LINE_MODE_VBLANK 1'h0
`define LINE_MODE_VHBLANK 1'h1
`define TEAR_EN_RESET 1'h0
`define LINE_MODE_RESET 1'h0

// scan order parameter layout
`define ROW_ORDER_POS 7
`define COLUMN_ORDER_POS 6
`define ROW_COLUMN_EXCHANGE_POS 5
`define REFRESH_DIRECTION_POS 4
`define COLOUR_ORDER_POS 3
`define LATCH_ORDER_POS 2
`define HORIZONTAL_MIRROR_POS 1
`define VERTICAL_MIRROR_POS 0
`define SCAN_ORDER_RESET 8'h00
`define SCAN_ORDER_WRITE_MASK 8'hfb

`endif

// [verilog/tear_scan_pkg.sv]
// types shared by the tear sync and scan order command logic
package tear_scan_pkg;

  // command decoder states
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_TEAR_PARAM = 2'b01,
    ST_TEAR_SKIP = 2'b10,
    ST_SCAN_PARAM = 2'b11
  } cmd_state_e;

  typedef logic [7:0] cmd_byte_t;

endpackage

// [verilog/cmd_bus_if.sv]
// byte stream from the host write port to the command decoder
`timescale 1ns/10ps
`default_nettype none

interface cmd_bus_if;
  logic byte_valid;
  logic is_data;
  logic [7:0] byte_val;

  modport src
  (
    output byte_valid,
    output is_data,
    output byte_val
  );

  modport dst
  (
    input byte_valid,
    input is_data,
    input byte_val
  );
endinterface

`default_nettype wire

// [verilog/host_write_port.sv]
// host parallel write port: pin synchronisers and write edge detection
`timescale 1ns/10ps
`default_nettype none

module host_write_port
  import tear_scan_pkg::*;
(
  // clock and synchronised reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // host pins
  input wire logic cs_n_i,
  input wire logic cmd_data_select_i,
  input wire logic write_strobe_n_i,
  input wire logic read_strobe_n_i,
  input wire logic [7:0] data_i,
  // byte stream out
  cmd_bus_if.src bus
);

  // pins bundled so one synchroniser pair covers them all
  localparam int PIN_W = 12;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic wr_n_prev;
  logic [PIN_W-1:0] pin_raw;

  assign pin_raw = {cs_n_i, cmd_data_select_i, write_strobe_n_i,
                    read_strobe_n_i, data_i};

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser per pin; first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          pin_meta[gi] <= 1'h1;
          pin_sync[gi] <= 1'h1;
        end
        else
        begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  // previous strobe level, taken from the synchronised copy only
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wr_n_prev <= 1'h1;
    else
      wr_n_prev <= pin_sync[9];
  end

  ////////////////////////////////////////////////////////////////////////
  // byte taken on the rising strobe edge with chip selected, no read
  logic write_edge;
  assign write_edge = pin_sync[9] && !wr_n_prev && !pin_sync[11] &&
                      pin_sync[8];

  // registered byte output, one-cycle valid pulse
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus.byte_valid <= 1'h0;
      bus.is_data <= 1'h0;
      bus.byte_val <= 8'h00;
    end
    else
    begin
      bus.byte_valid <= write_edge;
      if (write_edge)
      begin
        bus.is_data <= pin_sync[10];
        bus.byte_val <= pin_sync[7:0];
      end
    end
  end

endmodule

`default_nettype wire

// [tb/host_model.sv]
// host side model: drives the command pins of the write port
`timescale 1ns/10ps
`include "tear_scan_defs.svh"
`default_nettype none

module host_model
(
  // clock
  input wire logic clk_i,
  // host pins
  output logic cs_n_o,
  output logic dc_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic [7:0] data_o
);
  // idle pins: strobes and select high
  initial
  begin
    cs_n_o = 1'b1;
    dc_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    data_o = 8'h5a;
  end

  // one byte, eight clocks of setup and five of hold around the rising strobe
  task automatic put(input logic dc, input logic [7:0] b,
                     input logic cs_n, input logic rd_n);
    @(posedge clk_i);
    cs_n_o <= cs_n;
    dc_o <= dc;
    rd_n_o <= rd_n;
    data_o <= b;
    repeat (4) @(posedge clk_i);
    wr_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr_n_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    // released bus must not keep showing the byte
    data_o <= ~b;
  endtask

  // scan order write; latch bit kept clear, no scrolling ever used
  task automatic scan(input logic [7:0] b);
    put(1'b0, `CMD_SCAN_ORDER, 1'b0, 1'b1);
    put(1'b1, b & 8'hfb, 1'b0, 1'b1);
  endtask
endmodule

`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the tear sync and scan order decoder
`timescale 1ns/10ps
`include "tear_scan_defs.svh"
`default_nettype none

module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sleep = 1'b0;
  logic vb = 1'b0;
  logic hb = 1'b0;
  logic cs_n, dc, wr_n, rd_n;
  logic [7:0] data, scan;
  logic te, ten, tmode, rb, cb, xb, fb, ob, hm, vm;
  integer err_total = 0;
  integer n_tests = 0;
  integer seed = 32'h62bf;
  integer i;
  logic en_m = 1'b0;
  logic mode_m = 1'b0;
  logic chk_on = 1'b0;
  logic exp_q = 1'b0;
  logic [7:0] scan_m = 8'h00;
  wire [6:0] bits = {rb, cb, xb, fb, ob, hm, vm};

  always #2 clk = ~clk;

  tear_scan_ctrl dut
  (
    .clk_i(clk),
    .nrst_i(nrst),
    .cs_n_i(cs_n),
    .cmd_data_select_i(dc),
    .write_strobe_n_i(wr_n),
    .read_strobe_n_i(rd_n),
    .data_i(data),
    .sleep_mode_i(sleep),
    .vblank_i(vb),
    .hblank_i(hb),
    .tear_sync_out_o(te),
    .tear_enabled_o(ten),
    .tear_line_mode_sel_o(tmode),
    .scan_order_o(scan),
    .row_order_bit_o(rb),
    .column_order_bit_o(cb),
    .row_column_exchange_bit_o(xb),
    .refresh_direction_bit_o(fb),
    .colour_order_bit_o(ob),
    .horizontal_mirror_bit_o(hm),
    .vertical_mirror_bit_o(vm)
  );

  host_model host
  (
    .clk_i(clk),
    .cs_n_o(cs_n),
    .dc_o(dc),
    .wr_n_o(wr_n),
    .rd_n_o(rd_n),
    .data_o(data)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic tear_exp(input logic s, e, m, v, h);
    return s ? 1'b0 : (!e ? 1'b0 : (m ? (v | h) : v));
  endfunction

  function automatic logic [6:0] ebits(input logic [7:0] s);
    return {s[7:3], s[1:0]};
  endfunction

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic state_chk();
    check("scan", scan, scan_m);
    check("bits", bits, ebits(scan_m));
    check("tear on", ten, en_m);
    check("mode", tmode, mode_m);
  endtask

  task automatic done_test(input string name);
    $display("test %s done, %0d mismatches", name, err_total);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // random blanking and sleep; model of the registered tear pin
  always @(posedge clk)
  begin
    exp_q <= tear_exp(sleep, en_m, mode_m, vb, hb);
    vb <= 1'($random(seed));
    hb <= 1'($random(seed));
    sleep <= 3'($random(seed)) == 3'h0;
  end

  // tear pin checked every cycle while the model state is settled
  always @(negedge clk)
    if (chk_on)
      check("tear out", te, exp_q);

  // pin check paused while the enable may be in flight
  task automatic tear(input logic [7:0] c, input logic [7:0] p,
                      input logic wp);
    chk_on = 1'b0;
    host.put(1'b0, c, 1'b0, 1'b1);
    if (wp)
      host.put(1'b1, p, 1'b0, 1'b1);
    if (c == `CMD_TEAR_OFF)
      en_m = 1'b0;
    else if (c == `CMD_TEAR_ON && !en_m)
    begin
      en_m = 1'b1;
      mode_m = p[`LINE_MODE_BIT];
    end
    repeat (3) @(posedge clk);
    chk_on = 1'b1;
    state_chk();
  endtask

  // tear pin stays checked here: scan writes must not disturb it
  task automatic scan_w(input logic [7:0] v);
    host.scan(v);
    scan_m = v & 8'hfb;
    repeat (3) @(posedge clk);
    state_chk();
  endtask

  task automatic raw(input logic d, input logic [7:0] v,
                     input logic c, input logic r);
    host.put(d, v, c, r);
    repeat (3) @(posedge clk);
    state_chk();
  endtask

  task automatic do_reset();
    chk_on = 1'b0;
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    en_m = 1'b0;
    mode_m = 1'b0;
    scan_m = 8'h00;
    repeat (4) @(posedge clk);
    chk_on = 1'b1;
    state_chk();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    done_test("reset");
    scan_w(8'hff);
    scan_w(8'h00);
    for (i = 0; i < 6; i++)
      scan_w(8'($random(seed)));
    done_test("scan order");
    tear(`CMD_TEAR_ON, 8'hfe, 1'b1);
    repeat (40) @(posedge clk);
    scan_w(8'h10);
    tear(`CMD_TEAR_ON, 8'h01, 1'b1);
    repeat (40) @(posedge clk);
    done_test("tear vblank");
    tear(`CMD_TEAR_OFF, 8'h00, 1'b0);
    repeat (20) @(posedge clk);
    tear(`CMD_TEAR_ON, 8'h01, 1'b1);
    repeat (40) @(posedge clk);
    scan_w(8'h00);
    done_test("tear vhblank");
    // stray parameter, deselected, read strobe low, aborted, unknown
    raw(1'b1, 8'h12, 1'b0, 1'b1);
    raw(1'b0, `CMD_SCAN_ORDER, 1'b1, 1'b1);
    raw(1'b1, 8'h77, 1'b1, 1'b1);
    raw(1'b0, `CMD_SCAN_ORDER, 1'b0, 1'b0);
    raw(1'b1, 8'h99, 1'b0, 1'b0);
    raw(1'b0, `CMD_SCAN_ORDER, 1'b0, 1'b1);
    tear(`CMD_TEAR_OFF, 8'h00, 1'b0);
    raw(1'b1, 8'hee, 1'b0, 1'b1);
    raw(1'b0, 8'h37, 1'b0, 1'b1);
    raw(1'b1, 8'hcc, 1'b0, 1'b1);
    done_test("refused");
    tear(`CMD_TEAR_ON, 8'h01, 1'b1);
    scan_w(8'ha5);
    do_reset();
    done_test("mid reset");
    stop_test();
  end

  // sequence needs about 820 clocks; allow far more
  initial
  begin
    #100000;
    err_total++;
    stop_test();
  end
endmodule

`default_nettype wire
